// ### rtl/fwp_status_ctrl.sv
// Status register, write-enable latch and write protection of a serial flash.
// Behaviour
// - Refuse writes during power-up write delay.
// - Write enable latch clear at power-up.
// - Writes need write enable latch set.
// - Power-down accepts only release instruction.
// - Busy flag at S0 during operations.
// - Busy accepts only status read, suspend.
// - Operation done clears busy flag.
// - Write enable sets latch at S1.
// - Write disable and writes clear latch.
// - Three block-protect bits, default zero.
// - Top/bottom select, default top.
// - Granularity select: sectors or blocks.
// - Complement bit inverts protected region.
// - Two status-protect bits select mode.
// - Mode 00: pin ignored, latch suffices.
// - Mode 01: low pin locks status.
// - Mode 10: locked until power cycle.
// - Mode 11: status permanently locked.
// - Suspend flag set by 75h, cleared by 7Ah.
// - Security lock bits one-time settable.
// - Protect pin gates only outside quad.
// - Quad enable bit turns pins to data.
// - Ignore program/erase touching protected region.
`default_nettype none
`include "fwp_cfg.svh"
module fwp_status_ctrl
    import fwp_pkg::*;
#(
    parameter int unsigned PUW_CYCLES = `FWP_PUW_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire fwp_instr_type i_instr,
    input wire logic i_wp_n,
    input wire logic i_qpi_mode,
    input wire logic i_op_done,
    input wire logic i_nv_restore,
    input wire logic [15:0] i_nv_image,
    output logic [15:0] o_status,
    output logic o_quad_pins,
    output logic o_op_start,
    output fwp_kind_type o_op_kind,
    output logic o_op_suspend,
    output logic o_op_resume,
    output logic o_refused,
    output logic o_nv_commit
);
    fwp_state_type state_q;
    fwp_prot_type prot_q;
    fwp_kind_type kind_q;
    logic wel_q;
    logic [1:0] srp_q;
    logic qe_q;
    logic [3:0] lb_q;
    logic start_q;
    logic susp_q;
    logic resume_q;
    logic refused_q;
    logic commit_q;
    logic puw_done;
    logic hit;
    logic accept;
    logic refuse;
    logic is_prog;
    logic is_erase;
    logic is_wrsr;
    logic is_sec;
    logic writes;
    logic sr_locked;
    fwp_kind_type kind_d;
    logic [7:0] code;

    //--------------------------------------------------------------------
    // Power-up delay and protected-region decode
    //--------------------------------------------------------------------
    fwp_delay_timer #(
        .CYCLES(PUW_CYCLES)
    ) u_puw (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .o_done(puw_done)
    );

    fwp_region_check u_region (
        .i_prot(prot_q),
        .i_first(i_instr.first_sec),
        .i_last(i_instr.last_sec),
        .o_hit(hit)
    );

    //--------------------------------------------------------------------
    // Instruction decode and acceptance
    //--------------------------------------------------------------------
    assign code = i_instr.code;
    assign is_prog = (code == `FWP_OP_PP) || (code == `FWP_OP_QPP);
    assign is_erase = (code == `FWP_OP_SE) || (code == `FWP_OP_BE32) ||
        (code == `FWP_OP_BE64) || (code == `FWP_OP_CE1) || (code == `FWP_OP_CE2);
    assign is_wrsr = (code == `FWP_OP_WRSR);
    assign is_sec = (code == `FWP_OP_ERSEC) || (code == `FWP_OP_PGSEC);
    assign writes = is_prog || is_erase || is_wrsr || is_sec;

    // The protect pin acts only while it is not a quad data line.
    assign sr_locked = srp_q[1] || (srp_q[0] && !qe_q && !i_wp_n);

    always_comb
    begin
        accept = 1'b0;
        refuse = 1'b0;
        kind_d = FWP_K_NONE;
        if (is_prog)
            kind_d = FWP_K_PROG;
        else if (is_erase)
            kind_d = FWP_K_ERASE;
        else if (is_wrsr)
            kind_d = FWP_K_STATUS;
        else if (is_sec)
            kind_d = FWP_K_SECREG;
        if (i_instr.valid)
        begin
            unique case (state_q)
                FWP_ST_READY:
                begin
                    if (!puw_done && ((code == `FWP_OP_WREN) || writes))
                        refuse = 1'b1;
                    else if (writes && !wel_q)
                        refuse = 1'b1;
                    else if ((is_prog || is_erase) && hit)
                        refuse = 1'b1;
                    else if (is_sec && lb_q[i_instr.sec_idx])
                        refuse = 1'b1;
                    else if (is_wrsr && sr_locked)
                        refuse = 1'b1;
                    else
                        accept = 1'b1;
                end
                FWP_ST_BUSY:
                begin
                    // A finishing operation has nothing left to suspend.
                    if ((code == `FWP_OP_SUSPEND) && !i_op_done &&
                        ((kind_q == FWP_K_PROG) || (kind_q == FWP_K_ERASE)))
                        accept = 1'b1;
                    else if ((code == `FWP_OP_RDSR1) || (code == `FWP_OP_RDSR2))
                        accept = 1'b1;
                    else
                        refuse = 1'b1;
                end
                FWP_ST_SUSP:
                begin
                    if (writes || (code == `FWP_OP_PDOWN))
                        refuse = 1'b1;
                    else
                        accept = 1'b1;
                end
                FWP_ST_PDOWN:
                begin
                    if (code == `FWP_OP_RELEASE)
                        accept = 1'b1;
                    else
                        refuse = 1'b1;
                end
            endcase
        end
    end

    //--------------------------------------------------------------------
    // Operating state: busy, suspended, powered down
    //--------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_q <= FWP_ST_READY;
        end
        else
        begin
            unique case (state_q)
                FWP_ST_READY:
                begin
                    if (accept && writes)
                        state_q <= FWP_ST_BUSY;
                    else if (accept && (code == `FWP_OP_PDOWN))
                        state_q <= FWP_ST_PDOWN;
                end
                FWP_ST_BUSY:
                begin
                    if (i_op_done)
                        state_q <= FWP_ST_READY;
                    else if (accept && (code == `FWP_OP_SUSPEND))
                        state_q <= FWP_ST_SUSP;
                end
                FWP_ST_SUSP:
                begin
                    if (accept && (code == `FWP_OP_RESUME))
                        state_q <= FWP_ST_BUSY;
                end
                FWP_ST_PDOWN:
                begin
                    if (accept)
                        state_q <= FWP_ST_READY;
                end
            endcase
        end
    end

    //--------------------------------------------------------------------
    // Write enable latch
    //--------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wel_q <= 1'b0;
        end
        else if (accept && (state_q == FWP_ST_READY))
        begin
            if (code == `FWP_OP_WREN)
                wel_q <= 1'b1;
            else if ((code == `FWP_OP_WRDI) || writes)
                wel_q <= 1'b0;
        end
    end

    //--------------------------------------------------------------------
    // Non-volatile fields: restore at power-up, update on status write
    //--------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            prot_q <= '{cmp: 1'b0, gran: 1'b0, tb: 1'b0, bp: `FWP_RST_BP};
            srp_q <= `FWP_RST_SRP;
            qe_q <= 1'b0;
            lb_q <= `FWP_RST_LB;
        end
        else if (i_nv_restore && !puw_done)
        begin
            prot_q.bp <= i_nv_image[`FWP_BIT_BP_HI:`FWP_BIT_BP_LO];
            prot_q.tb <= i_nv_image[`FWP_BIT_TB];
            prot_q.gran <= i_nv_image[`FWP_BIT_GRAN];
            prot_q.cmp <= i_nv_image[`FWP_BIT_CMP];
            // Lock-down lasts only until the next power cycle.
            srp_q <= (i_nv_image[`FWP_BIT_SRP_HI:`FWP_BIT_SRP_LO] == 2'h2) ? 2'h0 :
                i_nv_image[`FWP_BIT_SRP_HI:`FWP_BIT_SRP_LO];
            qe_q <= i_nv_image[`FWP_BIT_QE];
            lb_q <= i_nv_image[`FWP_BIT_LB_HI:`FWP_BIT_LB_LO];
        end
        else if (accept && is_wrsr && (state_q == FWP_ST_READY))
        begin
            prot_q.bp <= i_instr.wdata[`FWP_BIT_BP_HI:`FWP_BIT_BP_LO];
            prot_q.tb <= i_instr.wdata[`FWP_BIT_TB];
            prot_q.gran <= i_instr.wdata[`FWP_BIT_GRAN];
            srp_q[0] <= i_instr.wdata[`FWP_BIT_SRP_LO];
            if (i_instr.wide)
            begin
                srp_q[1] <= i_instr.wdata[`FWP_BIT_SRP_HI];
                // In QPI mode the quad enable bit cannot drop.
                qe_q <= i_instr.wdata[`FWP_BIT_QE] || (qe_q && i_qpi_mode);
                lb_q <= lb_q | i_instr.wdata[`FWP_BIT_LB_HI:`FWP_BIT_LB_LO];
                prot_q.cmp <= i_instr.wdata[`FWP_BIT_CMP];
            end
        end
    end

    //--------------------------------------------------------------------
    // Operation strobes to the array engine
    //--------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            start_q <= 1'b0;
            kind_q <= FWP_K_NONE;
            susp_q <= 1'b0;
            resume_q <= 1'b0;
            refused_q <= 1'b0;
            commit_q <= 1'b0;
        end
        else
        begin
            start_q <= accept && writes && (state_q == FWP_ST_READY);
            if (accept && writes && (state_q == FWP_ST_READY))
                kind_q <= kind_d;
            susp_q <= accept && (state_q == FWP_ST_BUSY) && (code == `FWP_OP_SUSPEND);
            resume_q <= accept && (state_q == FWP_ST_SUSP) && (code == `FWP_OP_RESUME);
            refused_q <= refuse;
            commit_q <= accept && is_wrsr && (state_q == FWP_ST_READY);
        end
    end

    assign o_status = {state_q == FWP_ST_SUSP, prot_q.cmp, lb_q, qe_q, srp_q, prot_q.gran,
        prot_q.tb, prot_q.bp, wel_q, state_q == FWP_ST_BUSY};
    assign o_quad_pins = qe_q;
    assign o_op_start = start_q;
    assign o_op_kind = kind_q;
    assign o_op_suspend = susp_q;
    assign o_op_resume = resume_q;
    assign o_refused = refused_q;
    assign o_nv_commit = commit_q;

    //--------------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    chk_puw_refuse: assert property (i_instr.valid && !puw_done && (code == `FWP_OP_WREN)
        |=> !wel_q && o_refused) else $error("write enable taken in delay");
    chk_wel_powerup: assert property (!puw_done |-> !wel_q)
        else $error("latch set during power-up");
    chk_no_wel_refuse: assert property ((state_q == FWP_ST_READY) && i_instr.valid && writes
        && !wel_q |=> !o_op_start && o_refused) else $error("write without latch");
    chk_pdown_hold: assert property ((state_q == FWP_ST_PDOWN) && i_instr.valid &&
        (code != `FWP_OP_RELEASE) |=> (state_q == FWP_ST_PDOWN) && $stable(o_status))
        else $error("power-down left");
    chk_busy_start: assert property (o_op_start |-> o_status[`FWP_BIT_BUSY] && !wel_q)
        else $error("start without busy");
    chk_busy_ignore: assert property ((state_q == FWP_ST_BUSY) && i_instr.valid &&
        (code == `FWP_OP_PDOWN) |=> state_q != FWP_ST_PDOWN) else $error("busy took pdown");
    chk_done_clear: assert property ((state_q == FWP_ST_BUSY) && i_op_done
        |=> !o_status[`FWP_BIT_BUSY]) else $error("busy not cleared");
    chk_wren_set: assert property ((state_q == FWP_ST_READY) && i_instr.valid && puw_done &&
        (code == `FWP_OP_WREN) |=> wel_q) else $error("latch not set");
    chk_sr_otp: assert property (i_instr.valid && is_wrsr && (srp_q == 2'h3)
        |=> !o_op_start && $stable(o_status[14:2])) else $error("locked status written");
    chk_sus_set: assert property (o_op_suspend |-> o_status[`FWP_BIT_SUS] &&
        !o_status[`FWP_BIT_BUSY]) else $error("suspend flag missing");
    chk_lb_sticky: assert property (puw_done && $past(puw_done)
        |-> ($past(lb_q) & ~lb_q) == 4'h0) else $error("lock bit cleared");

    cov_status_write: cover property (o_nv_commit);
    cov_suspend_resume: cover property (o_op_suspend ##[1:50] o_op_resume);
    cov_protect_refuse: cover property (i_instr.valid && is_erase && hit && wel_q);
endmodule // fwp_status_ctrl
`default_nettype wire

// ### rtl/fwp_cfg.svh
// Constants of the flash write-protect and status block.
`ifndef FWP_CFG_SVH
`define FWP_CFG_SVH

// Status bit positions.
`define FWP_BIT_BUSY 0
`define FWP_BIT_WEL 1
`define FWP_BIT_BP_LO 2
`define FWP_BIT_BP_HI 4
`define FWP_BIT_TB 5
`define FWP_BIT_GRAN 6
`define FWP_BIT_SRP_LO 7
`define FWP_BIT_SRP_HI 8
`define FWP_BIT_QE 9
`define FWP_BIT_LB_LO 10
`define FWP_BIT_LB_HI 13
`define FWP_BIT_CMP 14
`define FWP_BIT_SUS 15

// Factory values of the non-volatile fields.
`define FWP_RST_BP 3'h0
`define FWP_RST_SRP 2'h0
`define FWP_RST_LB 4'h0

// Instruction codes.
`define FWP_OP_WREN 8'h06
`define FWP_OP_WRDI 8'h04
`define FWP_OP_WRSR 8'h01
`define FWP_OP_RDSR1 8'h05
`define FWP_OP_RDSR2 8'h35
`define FWP_OP_PP 8'h02
`define FWP_OP_QPP 8'h32
`define FWP_OP_SE 8'h20
`define FWP_OP_BE32 8'h52
`define FWP_OP_BE64 8'hD8
`define FWP_OP_CE1 8'hC7
`define FWP_OP_CE2 8'h60
`define FWP_OP_ERSEC 8'h44
`define FWP_OP_PGSEC 8'h42
`define FWP_OP_SUSPEND 8'h75
`define FWP_OP_RESUME 8'h7A
`define FWP_OP_PDOWN 8'hB9
`define FWP_OP_RELEASE 8'hAB

// Timing.
`define FWP_CLK_PERIOD_NS 10
`define FWP_PUW_US 1000
`define FWP_PUW_CYCLES ((`FWP_PUW_US * 1000 + `FWP_CLK_PERIOD_NS - 1) / `FWP_CLK_PERIOD_NS)

`endif

// ### rtl/fwp_pkg.sv
// Types of the flash write-protect and status block.
`default_nettype none
package fwp_pkg;

    typedef enum logic [1:0] {
        FWP_ST_READY = 2'h0,
        FWP_ST_BUSY = 2'h1,
        FWP_ST_SUSP = 2'h3,
        FWP_ST_PDOWN = 2'h2
    } fwp_state_type;

    typedef enum logic [2:0] {
        FWP_K_NONE = 3'h0,
        FWP_K_PROG = 3'h1,
        FWP_K_ERASE = 3'h2,
        FWP_K_STATUS = 3'h3,
        FWP_K_SECREG = 3'h4
    } fwp_kind_type;

    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic [15:0] wdata;
        logic wide;
        logic [9:0] first_sec;
        logic [9:0] last_sec;
        logic [1:0] sec_idx;
    } fwp_instr_type;

    typedef struct packed {
        logic cmp;
        logic gran;
        logic tb;
        logic [2:0] bp;
    } fwp_prot_type;

endpackage : fwp_pkg
`default_nettype wire

// ### rtl/fwp_delay_timer.sv
// Down counter that marks the end of a fixed delay after reset.
`default_nettype none
module fwp_delay_timer #(
    parameter int unsigned CYCLES = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    output logic o_done
);
    localparam int unsigned CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_q <= CW'(CYCLES);
        end
        else if (cnt_q != '0)
        begin
            cnt_q <= cnt_q - CW'(1);
        end
    end

    assign o_done = (cnt_q == '0);
endmodule // fwp_delay_timer
`default_nettype wire

// ### rtl/fwp_region_check.sv
// Tells whether a sector range touches the protected part of the array.
`default_nettype none
module fwp_region_check
    import fwp_pkg::*;
(
    input wire fwp_prot_type i_prot,
    input wire logic [9:0] i_first,
    input wire logic [9:0] i_last,
    output logic o_hit
);
    logic [10:0] n;
    logic [10:0] lo;
    logic [10:0] hi;

    // Size of the base region in 4KB sectors, before complement.
    always_comb
    begin
        if (i_prot.bp == 3'h0)
            n = 11'h000;
        else if (i_prot.bp == 3'h7)
            n = 11'h400;
        else if (i_prot.gran)
            n = (i_prot.bp[2]) ? 11'h008 : (11'h001 << (i_prot.bp - 3'h1));
        else
            n = 11'h010 << (i_prot.bp - 3'h1);
    end

    always_comb
    begin
        unique case ({i_prot.cmp, i_prot.tb})
            2'h0:
            begin
                lo = 11'h400 - n;
                hi = 11'h400;
            end
            2'h1:
            begin
                lo = 11'h000;
                hi = n;
            end
            2'h2:
            begin
                lo = 11'h000;
                hi = 11'h400 - n;
            end
            2'h3:
            begin
                lo = n;
                hi = 11'h400;
            end
        endcase
    end

    assign o_hit = (lo < hi) && ({1'b0, i_first} < hi) && ({1'b0, i_last} >= lo);
endmodule // fwp_region_check
`default_nettype wire

// ### dv/fwp_host_model.sv
// Host controller model: issues decoded instructions and ends array operations.
`default_nettype none
module fwp_host_model
    import fwp_pkg::*;
(
    input wire logic i_ref_clk,
    output var fwp_instr_type o_instr,
    output var logic o_op_done
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        o_instr = '0;
        o_op_done = 1'b0;
    end

    // ----------------------------------------------------------------
    // Instruction issue
    // ----------------------------------------------------------------
    // Holds one instruction for exactly one taking edge; answer pulses are visible on return.
    task automatic issue(input logic [7:0] code, input logic [15:0] wdata = 16'h0000,
        input logic wide = 1'b0, input logic [9:0] first = 10'h000,
        input logic [9:0] last = 10'h000, input logic [1:0] idx = 2'h0);
        @(negedge i_ref_clk);
        o_instr = {1'b1, code, wdata, wide, first, last, idx};
        @(negedge i_ref_clk);
        o_instr.valid = 1'b0;
    endtask

    // Issues a write enable, then the given program, erase or status write.
    task automatic enabled(input logic [7:0] code, input logic [15:0] wdata = 16'h0000,
        input logic wide = 1'b0, input logic [9:0] first = 10'h000,
        input logic [9:0] last = 10'h000, input logic [1:0] idx = 2'h0);
        issue(8'h06);
        issue(code, wdata, wide, first, last, idx);
    endtask

    // The array engine reports the end of the running operation with one pulse.
    task automatic finish();
        @(negedge i_ref_clk);
        o_op_done = 1'b1;
        @(negedge i_ref_clk);
        o_op_done = 1'b0;
    endtask
endmodule // fwp_host_model
`default_nettype wire

// ### dv/flash_write_protect_status_tb.sv
// Self-checking testbench of the flash write-protect and status block.
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module flash_write_protect_status_tb;
    import fwp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned PUW = 8;
    logic i_ref_clk;
    logic i_rst_n;
    logic i_wp_n;
    logic i_qpi_mode;
    logic i_nv_restore;
    logic [15:0] i_nv_image;
    wire fwp_instr_type instr;
    wire logic op_done;
    logic [15:0] status;
    logic quad_pins, op_start, op_suspend, op_resume, refused, nv_commit;
    fwp_kind_type op_kind;
    int n_fail = 0;
    int check_count = 0;

    fwp_host_model u_host (
        .i_ref_clk(i_ref_clk),
        .o_instr(instr),
        .o_op_done(op_done)
    );

    fwp_status_ctrl #(
        .PUW_CYCLES(PUW)
    ) u_dut (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_instr(instr),
        .i_wp_n(i_wp_n),
        .i_qpi_mode(i_qpi_mode),
        .i_op_done(op_done),
        .i_nv_restore(i_nv_restore),
        .i_nv_image(i_nv_image),
        .o_status(status),
        .o_quad_pins(quad_pins),
        .o_op_start(op_start),
        .o_op_kind(op_kind),
        .o_op_suspend(op_suspend),
        .o_op_resume(op_resume),
        .o_refused(refused),
        .o_nv_commit(nv_commit)
    );

    initial
    begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Power cycle, then restore the non-volatile image inside the power-up delay.
    task automatic power_cycle(input logic [15:0] image);
        i_rst_n = 1'b0;
        repeat (2) @(negedge i_ref_clk);
        `CHK("status in reset", 16'h0000, status)
        i_rst_n = 1'b1;
        @(negedge i_ref_clk);
        i_nv_restore = 1'b1;
        i_nv_image = image;
        @(negedge i_ref_clk);
        i_nv_restore = 1'b0;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial
    begin
        i_wp_n = 1'b1;
        i_qpi_mode = 1'b0;
        i_nv_restore = 1'b0;
        i_nv_image = 16'h0000;
        power_cycle(16'h0104);
        `CHK("restored status", 16'h0004, status)
        u_host.issue(8'h06);
        `CHK("enable in delay", 1'b1, refused)
        `CHK("latch in delay", 1'b0, status[1])
        repeat (PUW) @(negedge i_ref_clk);
        u_host.issue(8'h01, 16'h0010);
        `CHK("write without latch", 1'b1, refused)
        `CHK("status kept", 16'h0004, status)
        u_host.issue(8'h06);
        `CHK("latch set", 16'h0006, status)
        u_host.issue(8'h04);
        `CHK("latch cleared", 16'h0004, status)
        u_host.issue(8'hB9);
        u_host.issue(8'h06);
        `CHK("enable in power-down", 1'b1, refused)
        u_host.issue(8'hAB);
        u_host.enabled(8'h20, 16'h0000, 1'b0, 10'h3F0, 10'h3F0);
        `CHK("protected erase", 1'b1, refused)
        u_host.issue(8'h20, 16'h0000, 1'b0, 10'h000, 10'h00F);
        `CHK("erase start", 1'b1, op_start)
        `CHK("erase kind", FWP_K_ERASE, op_kind)
        `CHK("erase busy", 16'h0005, status)
        u_host.issue(8'h06);
        `CHK("enable while busy", 1'b1, refused)
        u_host.issue(8'hB9);
        `CHK("power-down while busy", 1'b1, refused)
        u_host.issue(8'h05);
        `CHK("status read while busy", 1'b0, refused)
        u_host.issue(8'h75);
        `CHK("suspend pulse", 1'b1, op_suspend)
        `CHK("suspended", 16'h8004, status)
        u_host.issue(8'h7A);
        `CHK("resume pulse", 1'b1, op_resume)
        `CHK("resumed", 16'h0005, status)
        u_host.finish();
        `CHK("erase done", 16'h0004, status)
        i_wp_n = 1'b0;
        u_host.enabled(8'h01, 16'h44E4, 1'b1);
        `CHK("software mode write", 1'b1, nv_commit)
        `CHK("write kind", FWP_K_STATUS, op_kind)
        `CHK("fields written", 16'h44E5, status)
        u_host.finish();
        u_host.enabled(8'h20, 16'h0000, 1'b0, 10'h001, 10'h001);
        `CHK("complemented region", 1'b1, refused)
        u_host.issue(8'h20, 16'h0000, 1'b0, 10'h000, 10'h000);
        `CHK("bottom sector erase", 1'b1, op_start)
        `CHK("bottom sector busy", 16'h44E5, status)
        u_host.finish();
        u_host.enabled(8'h01, 16'h0000, 1'b1);
        `CHK("pin low locks", 1'b1, refused)
        `CHK("refused keeps", 16'h44E6, status)
        i_wp_n = 1'b1;
        u_host.enabled(8'h01, 16'h0280, 1'b1);
        `CHK("pin high writes", 16'h0681, status)
        u_host.finish();
        `CHK("quad pins", 1'b1, quad_pins)
        i_wp_n = 1'b0;
        u_host.enabled(8'h01, 16'h0300, 1'b1);
        `CHK("quad ignores pin", 16'h0701, status)
        u_host.finish();
        u_host.enabled(8'h01, 16'h0000);
        `CHK("lock-down", 1'b1, refused)
        u_host.issue(8'h42, 16'h0000, 1'b0, 10'h000, 10'h000, 2'h0);
        `CHK("locked security", 1'b1, refused)
        u_host.issue(8'h42, 16'h0000, 1'b0, 10'h000, 10'h000, 2'h1);
        `CHK("security kind", FWP_K_SECREG, op_kind)
        `CHK("security busy", 16'h0701, status)
        u_host.finish();
        power_cycle(16'h0700);
        `CHK("lock-down released", 16'h0600, status)
        repeat (PUW) @(negedge i_ref_clk);
        i_qpi_mode = 1'b1;
        u_host.enabled(8'h01, 16'h0000, 1'b1);
        `CHK("quad enable kept", 16'h0601, status)
        u_host.finish();
        i_qpi_mode = 1'b0;
        u_host.enabled(8'h01, 16'h0380, 1'b1);
        `CHK("permanent set", 16'h0781, status)
        u_host.finish();
        u_host.enabled(8'h01, 16'h0000, 1'b1);
        `CHK("permanent lock", 1'b1, refused)
        `CHK("permanent keeps", 16'h0782, status)
        i_nv_restore = 1'b1;
        i_nv_image = 16'h0000;
        @(negedge i_ref_clk);
        i_nv_restore = 1'b0;
        `CHK("late restore ignored", 16'h0782, status)
        summarize();
    end

    initial
    begin
        repeat (5000) @(posedge i_ref_clk);
        n_fail++;
        summarize();
    end
endmodule // flash_write_protect_status_tb
`undef CHK
`default_nettype wire
